//--- hdl/flash_ctrl_consts.vh
// Constants for the flash program and erase controller.
`ifndef FLASH_CTRL_CONSTS_VH
`define FLASH_CTRL_CONSTS_VH
`define ADDR_CMD_STAT     12'hFF8
`define ADDR_PAGE_SEL     12'hFF9
`define ADDR_FREQ_HI      12'hFFA
`define ADDR_FREQ_LO      12'hFFB
`define CMD_RESET         8'h00
`define CMD_UNLOCK1       8'h73
`define CMD_UNLOCK2       8'h8C
`define CMD_PAGE_ERASE    8'h95
`define CMD_MASS_ERASE    8'h63
`define CMD_SECT_SEL      8'h5E
`define ST_LOCKED         6'h00
`define ST_FIRST          6'h01
`define ST_SECOND         6'h02
`define ST_UNLOCKED       6'h03
`define ST_SECT_SEL       6'h04
`define ST_PROGRAM        6'h08
`define ST_ERASE          6'h10
`define INFO_BASE         16'hFE00
`define INFO_ID_FIRST     9'h040
`define INFO_ID_LAST      9'h053
`define INFO_OVERLAY_SELECT_BIT       7
`define ERASED_BYTE       8'hFF
`define RST_PAGE_SEL      8'h00
`define RST_SECT_GUARD    8'h00
`define RST_FREQ          16'h0000
`define PROG_TIME_US      20
`define ERASE_TIME_US     10000
`endif

//--- hdl/info_area_rom.v
// Read-only information area holding the part identifier.
`timescale 1ns/10ps
module info_area_rom #(
    // Arbitrary identifier, left-justified with zero bytes at the low end.
    parameter [159:0] PART_ID = {"TESTPART0001", 64'h0000000000000000}
) (
    input  wire       clk_i,
    input  wire [8:0] addr_i,
    output reg  [7:0] data_o
);
    `include "flash_ctrl_consts.vh"
    wire [8:0] idx = addr_i - `INFO_ID_FIRST;
    wire       hit = (addr_i >= `INFO_ID_FIRST) &&
                     (addr_i <= `INFO_ID_LAST);
    // Characters are left-justified; unused trailing bytes read zero.
    wire [4:0] chr = 5'd19 - idx[4:0];
    always @(posedge clk_i) begin
        if (hit) begin
            data_o <= PART_ID[chr*8 +: 8]; // [RQ4]
        end else begin
            data_o <= 8'h00;
        end
    end
endmodule

//--- hdl/flash_program_erase_controller.v
// Flash lock sequencer, sector guard, info overlay and op timing.
`timescale 1ns/10ps
`include "flash_ctrl_consts.vh"
// Functional notes
// [RQ1] Info select bit 7 overlays 512-byte info area at FE00h-FFFFh.
// [RQ2] Overlay serves data loads only; instruction fetches read normal memory.
// [RQ3] Info area is read-only; writes never change it.
// [RQ4] Info area holds 20-char ASCII part id at FE40h-FE53h, zero padded.
// [RQ5] Frequency high and low bytes form 16-bit kHz value for timing.
// [RQ6] Software loads frequency first; clocks 32 kHz to 20 MHz only.
// [RQ7] Read protect blocks debug and bypass reads of user code; code gates debug reads only, with no bypass path.
// [RQ8] Locked at reset and on any out-of-sequence command or page write.
// [RQ9] Unlock: 00h, page, 73h, 8Ch, same page again.
// [RQ10] Sector guard clears at reset; user writes only set bits.
// [RQ11] Command 5Eh maps sector guard at FF9h instead of page select.
// [RQ12] Any command write deselects the sector guard.
// [RQ13] Write-protect option refuses all user program and erase.
// [RQ14] Unlocked writes program only inside the unlocked page.
// [RQ15] Programming only clears bits; erased byte reads FFh.
// [RQ16] CPU stalls during program; interrupts deferred until done.
// [RQ17] Command 00h leaves programming mode and locks.
// [RQ18] Program or erase refused on pages of protected sectors.
// [RQ19] Command 95h after unlock erases selected page to FFh, stalling CPU.
// [RQ20] Page erase completion returns controller to locked.
// [RQ21] User code can never mass erase.
// [RQ22] Software programs a location at most twice between erases.
// [RQ23] Page field bits 6:0 give program address bits 15:9.
// [RQ24] Command write and status read share one address.
// [RQ25] Status reads 0,1,2,3 for locked, first, second, unlocked.
// [RQ26] Writes while locked are ignored and leave the array untouched.
module flash_program_erase_controller #(
    parameter         CLK_KHZ       = 25000,
    // Arbitrary identifier, left-justified with zero bytes at the low end.
    parameter [159:0] PART_ID       = {"TESTPART0001", 64'h0000000000000000},
    parameter [31:0]  ERASE_CYC_MAX = 32'd200000
) (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [11:0] reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire        mem_wr_i,
    input  wire        mem_load_i,
    input  wire        mem_fetch_i,
    input  wire [15:0] mem_addr_i,
    input  wire [7:0]  mem_wdata_i,
    output reg  [7:0]  mem_rdata_o,
    input  wire        debug_read_i,
    input  wire        write_protect_i,
    input  wire        read_protect_i,
    output reg         cpu_stall_o,
    output reg         irq_defer_o,
    output reg         debug_read_block_o,
    output reg         arr_prog_o,
    output reg         arr_erase_o,
    output reg  [15:0] arr_addr_o,
    output reg  [7:0]  arr_wdata_o,
    input  wire [7:0]  arr_rdata_i
);
    localparam S_LOCKED   = 3'd0;
    localparam S_FIRST    = 3'd1;
    localparam S_SECOND   = 3'd2;
    localparam S_UNLOCKED = 3'd3;
    localparam S_SECT     = 3'd4;
    localparam S_PROG     = 3'd5;
    localparam S_ERASE    = 3'd6;
    localparam S_PAGE     = 3'd7;
    localparam [15:0] RST_FREQ_W = `RST_FREQ;

    reg  [2:0]  state_q;
    reg  [7:0]  page_sel_q;
    reg  [7:0]  sect_guard_q;
    reg  [7:0]  freq_hi_q;
    reg  [7:0]  freq_lo_q;
    reg  [31:0] count_q;
    reg  [7:0]  load_sel_q;
    wire [7:0]  info_data;
    reg  [7:0]  arr_rdata_q;

    wire [15:0] freq_khz = {freq_hi_q, freq_lo_q}; // [RQ5]
    // Cycles = kHz * us / 1000 plus one, so at least one.
    wire [31:0] prog_cyc  = ({16'h0000, freq_khz} * `PROG_TIME_US)
                            / 32'd1000 + 32'd1; // [RQ5]
    wire [31:0] erase_raw = ({16'h0000, freq_khz} * `ERASE_TIME_US)
                            / 32'd1000 + 32'd1;
    wire [31:0] erase_cyc = (erase_raw > ERASE_CYC_MAX) ?
                            ERASE_CYC_MAX : erase_raw;

    wire [6:0] page   = page_sel_q[6:0];
    // Eight sectors over 32 pages: four pages per sector.
    wire [2:0] sector = page[4:2];
    wire       guarded = sect_guard_q[sector] | write_protect_i; // [RQ13] [RQ18]
    wire       wr_cmd  = reg_wr_i && (reg_addr_i == `ADDR_CMD_STAT);
    wire       wr_page = reg_wr_i && (reg_addr_i == `ADDR_PAGE_SEL);
    wire       in_page = (mem_addr_i[15:9] == page); // [RQ14] [RQ23]
    wire       info_on = page_sel_q[`INFO_OVERLAY_SELECT_BIT];
    wire       info_hit = info_on && (mem_addr_i >= `INFO_BASE);
    wire       stalled = (state_q == S_PROG) || (state_q == S_ERASE);
    // Launch conditions shared by the sequencer and the array outputs.
    wire       prog_go  = !wr_cmd && !wr_page && mem_wr_i &&
                          state_q == S_UNLOCKED && in_page && !guarded &&
                          !info_hit; // [RQ3] [RQ14] [RQ26]
    wire       erase_go = wr_cmd && reg_wdata_i == `CMD_PAGE_ERASE &&
                          state_q == S_UNLOCKED && !guarded; // [RQ19]
    // Stall rises on the launching edge, so the CPU never slips a cycle.
    wire       stall_d  = prog_go || erase_go ||
                          (stalled && count_q > 32'd1); // [RQ16] [RQ19]

    reg [5:0] status;
    always @* begin
        case (state_q)
            S_LOCKED:   status = `ST_LOCKED; // [RQ25]
            S_FIRST:    status = `ST_FIRST;
            S_SECOND:   status = `ST_SECOND;
            S_PAGE:     status = `ST_SECOND;
            S_UNLOCKED: status = `ST_UNLOCKED;
            S_SECT:     status = `ST_SECT_SEL;
            S_PROG:     status = `ST_PROGRAM;
            S_ERASE:    status = `ST_ERASE;
            default:    status = `ST_LOCKED;
        endcase
    end

    info_area_rom #(
        .PART_ID (PART_ID)
    ) u_info (
        .clk_i   (clk_i),
        .addr_i  (mem_addr_i[8:0]),
        .data_o  (info_data)
    );

    // Lock sequencer and page/guard registers.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q      <= S_LOCKED; // [RQ8]
            page_sel_q   <= `RST_PAGE_SEL;
            sect_guard_q <= `RST_SECT_GUARD; // [RQ10]
            freq_hi_q    <= RST_FREQ_W[15:8];
            freq_lo_q    <= RST_FREQ_W[7:0];
            count_q      <= 32'd0;
        end else begin
            if (reg_wr_i && reg_addr_i == `ADDR_FREQ_HI) begin
                freq_hi_q <= reg_wdata_i;
            end
            if (reg_wr_i && reg_addr_i == `ADDR_FREQ_LO) begin
                freq_lo_q <= reg_wdata_i;
            end
            case (state_q)
                S_PROG: begin
                    if (count_q <= 32'd1) begin
                        state_q <= S_UNLOCKED; // [RQ16]
                    end else begin
                        count_q <= count_q - 32'd1;
                    end
                end
                S_ERASE: begin
                    if (count_q <= 32'd1) begin
                        state_q <= S_LOCKED; // [RQ20]
                    end else begin
                        count_q <= count_q - 32'd1;
                    end
                end
                default: begin
                    if (wr_cmd) begin
                        // Every command write also drops guard selection.
                        state_q <= S_LOCKED; // [RQ8] [RQ12] [RQ17] [RQ21]
                        if (reg_wdata_i == `CMD_UNLOCK1 &&
                            state_q == S_LOCKED) begin
                            state_q <= S_FIRST; // [RQ9]
                        end
                        if (reg_wdata_i == `CMD_UNLOCK2 &&
                            state_q == S_FIRST) begin
                            state_q <= S_SECOND; // [RQ9]
                        end
                        if (reg_wdata_i == `CMD_SECT_SEL &&
                            state_q == S_LOCKED) begin
                            state_q <= S_SECT; // [RQ11]
                        end
                        if (reg_wdata_i == `CMD_PAGE_ERASE &&
                            state_q == S_UNLOCKED && !guarded) begin
                            state_q <= S_ERASE; // [RQ19]
                            count_q <= erase_cyc;
                        end
                    end else if (wr_page) begin
                        case (state_q)
                            S_LOCKED:
                                page_sel_q <= reg_wdata_i;
                            S_SECT:
                                sect_guard_q <= sect_guard_q |
                                                reg_wdata_i; // [RQ10] [RQ11]
                            S_SECOND: begin
                                if (reg_wdata_i == page_sel_q) begin
                                    state_q <= S_UNLOCKED; // [RQ9]
                                end else begin
                                    state_q <= S_LOCKED; // [RQ8]
                                end
                            end
                            default:
                                state_q <= S_LOCKED; // [RQ8]
                        endcase
                    end else if (prog_go) begin
                        state_q <= S_PROG; // [RQ14] [RQ26]
                        count_q <= prog_cyc;
                    end
                end
            endcase
        end
    end

    // Array drive and CPU-facing outputs.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            arr_prog_o         <= 1'b0;
            arr_erase_o        <= 1'b0;
            arr_addr_o         <= 16'h0000;
            arr_wdata_o        <= `ERASED_BYTE;
            cpu_stall_o        <= 1'b0;
            irq_defer_o        <= 1'b0;
            debug_read_block_o <= 1'b0;
            reg_rdata_o        <= 8'h00;
            load_sel_q         <= 8'h00;
        end else begin
            arr_prog_o  <= 1'b0;
            arr_erase_o <= 1'b0;
            if (prog_go) begin
                arr_prog_o  <= 1'b1; // [RQ14] [RQ3] [RQ26]
                arr_addr_o  <= mem_addr_i;
                // The array only pulls bits low, so AND with current data.
                arr_wdata_o <= mem_wdata_i & arr_rdata_i; // [RQ15]
            end else if (erase_go) begin
                arr_erase_o <= 1'b1; // [RQ19]
                arr_addr_o  <= {page, 9'h000}; // [RQ23]
                arr_wdata_o <= `ERASED_BYTE; // [RQ15]
            end
            cpu_stall_o <= stall_d; // [RQ16] [RQ19]
            irq_defer_o <= stall_d; // [RQ16]
            debug_read_block_o <= read_protect_i && debug_read_i; // [RQ7]
            if (reg_rd_i && reg_addr_i == `ADDR_CMD_STAT) begin
                reg_rdata_o <= {2'b00, status}; // [RQ24]
            end else if (reg_rd_i && reg_addr_i == `ADDR_PAGE_SEL) begin
                reg_rdata_o <= (state_q == S_SECT) ? sect_guard_q :
                               page_sel_q; // [RQ11]
            end else if (reg_rd_i && reg_addr_i == `ADDR_FREQ_HI) begin
                reg_rdata_o <= freq_hi_q;
            end else if (reg_rd_i && reg_addr_i == `ADDR_FREQ_LO) begin
                reg_rdata_o <= freq_lo_q;
            end else begin
                reg_rdata_o <= 8'h00;
            end
            load_sel_q <= (mem_load_i && !mem_fetch_i && info_hit) ?
                          8'hFF : 8'h00; // [RQ1] [RQ2]
        end
    end

    // Loads answer two cycles after the request: the info byte, the select
    // mask and the array byte are all registered on one edge, then muxed.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            arr_rdata_q <= 8'h00;
            mem_rdata_o <= 8'h00;
        end else begin
            arr_rdata_q <= arr_rdata_i;
            mem_rdata_o <= (info_data & load_sel_q) |
                           (arr_rdata_q & ~load_sel_q); // [RQ1] [RQ2]
        end
    end
endmodule

//--- bench/flash_array_model.sv
// Behavioural flash array on the far side of the controller.
`timescale 1ns/10ps
module flash_array_model (
    input  wire        clk_i,
    input  wire        prog_i,
    input  wire        erase_i,
    input  wire [15:0] addr_i,
    input  wire [7:0]  wdata_i,
    input  wire [15:0] rd_addr_i,
    output wire [7:0]  rdata_o
);
    reg [7:0] mem [0:65535];
    integer   i;
    integer   j;
    initial begin
        for (i = 0; i < 65536; i = i + 1)
            mem[i] = 8'hFF;
    end
    assign rdata_o = mem[rd_addr_i];
    // A program pulse can only pull bits down, as real cells do.
    always @(posedge clk_i) begin
        if (prog_i)
            mem[addr_i] <= mem[addr_i] & wdata_i;
        if (erase_i) begin
            for (j = 0; j < 512; j = j + 1)
                mem[{addr_i[15:9], j[8:0]}] <= 8'hFF;
        end
    end
endmodule

//--- bench/flash_ctrl_properties.sv
// Port-level assertions for the flash program and erase controller.
`timescale 1ns/10ps
module flash_ctrl_properties (
    input wire        clk_i,
    input wire        sys_rst_i,
    input wire        reg_wr_i,
    input wire [11:0] reg_addr_i,
    input wire [7:0]  reg_wdata_i,
    input wire        mem_wr_i,
    input wire        mem_fetch_i,
    input wire [15:0] mem_addr_i,
    input wire [7:0]  arr_rdata_i,
    input wire [7:0]  mem_rdata_o,
    input wire        debug_read_i,
    input wire        write_protect_i,
    input wire        read_protect_i,
    input wire        cpu_stall_o,
    input wire        irq_defer_o,
    input wire        debug_read_block_o,
    input wire        arr_prog_o,
    input wire        arr_erase_o,
    input wire [15:0] arr_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire cmd_wr    = reg_wr_i && (reg_addr_i == 12'hFF8);
    wire erase_cmd = cmd_wr && (reg_wdata_i == 8'h95);
    dbg_block_a: assert property (read_protect_i && debug_read_i |=>
        debug_read_block_o) else $error("debug read not blocked");
    wp_refuse_a: assert property (write_protect_i |=>
        !arr_prog_o && !arr_erase_o) else $error("op under write protect");
    prog_cause_a: assert property (arr_prog_o |->
        $past(mem_wr_i) && arr_addr_o == $past(mem_addr_i))
        else $error("stray program pulse");
    fetch_array_a: assert property (mem_fetch_i |=> ##1
        mem_rdata_o == $past(arr_rdata_i, 2)) else $error("fetch not array");
    erase_cause_a: assert property (arr_erase_o |->
        $past(erase_cmd)) else $error("stray erase");
    no_mass_a: assert property (cmd_wr && reg_wdata_i == 8'h63 |=>
        !arr_erase_o) else $error("mass erase started");
    erase_stall_a: assert property (arr_erase_o |-> cpu_stall_o)
        else $error("no stall in erase");
    defer_irq_a: assert property (cpu_stall_o |-> irq_defer_o)
        else $error("irq not deferred");
    busy_refuse_a: assert property (cpu_stall_o && mem_wr_i |=>
        !arr_prog_o) else $error("write taken while busy");
    stall_end_a: assert property ($rose(cpu_stall_o) |->
        ##[1:1000] !cpu_stall_o) else $error("stall never ends");
    cover property (arr_erase_o);
    cover property (arr_prog_o);
    cover property (debug_read_block_o);
endmodule

//--- bench/flash_program_erase_controller_tb_top.sv
// Self-checking bench for the flash program and erase controller.
`timescale 1ns/10ps
`define CHK(a, b) begin \
    check_count = check_count + 1; \
    if ((a) !== (b)) begin \
        err_count = err_count + 1; \
        $display("Error at %0t got %h exp %h", $time, a, b); \
    end \
end
module flash_program_erase_controller_tb_top;
    reg         clk_i = 1'b0;
    reg         sys_rst_i = 1'b1;
    reg         reg_wr_i = 1'b0, reg_rd_i = 1'b0, mem_wr_i = 1'b0;
    reg         mem_load_i = 1'b0, mem_fetch_i = 1'b0;
    reg         debug_read_i = 1'b0, write_protect_i = 1'b0;
    reg         read_protect_i = 1'b0;
    reg  [11:0] reg_addr_i = 12'h000;
    reg  [7:0]  reg_wdata_i = 8'h00, mem_wdata_i = 8'h00, rd;
    reg  [15:0] mem_addr_i = 16'h0000;
    wire [7:0]  reg_rdata_o, mem_rdata_o, arr_wdata_o, arr_rdata_i;
    wire [15:0] arr_addr_o;
    wire        cpu_stall_o, irq_defer_o, debug_read_block_o;
    wire        arr_prog_o, arr_erase_o;
    integer     err_count = 0, check_count = 0, cycles = 0, n;
    always #20 clk_i = ~clk_i;
    flash_program_erase_controller #(
        .PART_ID       ("ABCDEFGHIJKLMNOPQRST"),
        .ERASE_CYC_MAX (32'd50)
    ) dut (
        .clk_i              (clk_i),
        .sys_rst_i          (sys_rst_i),
        .reg_wr_i           (reg_wr_i),
        .reg_rd_i           (reg_rd_i),
        .reg_addr_i         (reg_addr_i),
        .reg_wdata_i        (reg_wdata_i),
        .reg_rdata_o        (reg_rdata_o),
        .mem_wr_i           (mem_wr_i),
        .mem_load_i         (mem_load_i),
        .mem_fetch_i        (mem_fetch_i),
        .mem_addr_i         (mem_addr_i),
        .mem_wdata_i        (mem_wdata_i),
        .mem_rdata_o        (mem_rdata_o),
        .debug_read_i       (debug_read_i),
        .write_protect_i    (write_protect_i),
        .read_protect_i     (read_protect_i),
        .cpu_stall_o        (cpu_stall_o),
        .irq_defer_o        (irq_defer_o),
        .debug_read_block_o (debug_read_block_o),
        .arr_prog_o         (arr_prog_o),
        .arr_erase_o        (arr_erase_o),
        .arr_addr_o         (arr_addr_o),
        .arr_wdata_o        (arr_wdata_o),
        .arr_rdata_i        (arr_rdata_i)
    );
    flash_array_model far (.clk_i(clk_i), .prog_i(arr_prog_o),
        .erase_i(arr_erase_o), .addr_i(arr_addr_o), .wdata_i(arr_wdata_o),
        .rd_addr_i(mem_addr_i), .rdata_o(arr_rdata_i));
    task report_and_stop;
        begin
            $display("Checks %0d mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            report_and_stop;
        end
    end
    task idle;
        begin
            repeat (2) @(posedge clk_i);
            #1;
            for (n = 0; n < 200 && cpu_stall_o !== 1'b0; n = n + 1) begin
                @(posedge clk_i);
                #1;
            end
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            #1;
            reg_wr_i = 1'b1;
            reg_addr_i = a;
            reg_wdata_i = d;
            @(posedge clk_i);
            #1;
            reg_wr_i = 1'b0;
        end
    endtask
    task mwr(input [15:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            #1;
            mem_wr_i = 1'b1;
            mem_addr_i = a;
            mem_wdata_i = d;
            @(posedge clk_i);
            #1;
            mem_wr_i = 1'b0;
            idle;
        end
    endtask
    // Kind 0 reads a register, 1 loads data, 2 fetches code.
    // Register reads answer one cycle later, memory reads two.
    task chk(input [1:0] k, input [15:0] a, input [7:0] e);
        begin
            @(posedge clk_i);
            #1;
            reg_rd_i = (k == 2'd0);
            mem_load_i = (k == 2'd1);
            mem_fetch_i = (k == 2'd2);
            reg_addr_i = a[11:0];
            mem_addr_i = a;
            @(posedge clk_i);
            #1;
            {reg_rd_i, mem_load_i, mem_fetch_i} = 3'b000;
            if (k != 2'd0) begin
                @(posedge clk_i);
                #1;
            end
            rd = (k == 2'd0) ? reg_rdata_o : mem_rdata_o;
            `CHK(rd, e)
        end
    endtask
    task unlock(input [7:0] p);
        begin
            wr(12'hFF8, 8'h00);
            wr(12'hFF9, p);
            wr(12'hFF8, 8'h73);
            wr(12'hFF8, 8'h8C);
            wr(12'hFF9, p);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        chk(0, 16'h0FF8, 8'h00);
        chk(0, 16'h0FF9, 8'h00);
        wr(12'hFFA, 8'h00);
        wr(12'hFFB, 8'h05);
        wr(12'hFF8, 8'h00);
        wr(12'hFF9, 8'h02);
        wr(12'hFF8, 8'h73);
        chk(0, 16'h0FF8, 8'h01);
        wr(12'hFF8, 8'h8C);
        chk(0, 16'h0FF8, 8'h02);
        wr(12'hFF9, 8'h02);
        chk(0, 16'h0FF8, 8'h03);
        mwr(16'h0410, 8'hA5);
        chk(1, 16'h0410, 8'hA5);
        mwr(16'h0410, 8'h0F);
        chk(1, 16'h0410, 8'h05);
        mwr(16'h0610, 8'h00);
        chk(1, 16'h0610, 8'hFF);
        write_protect_i = 1'b1;
        mwr(16'h0411, 8'h00);
        write_protect_i = 1'b0;
        chk(1, 16'h0411, 8'hFF);
        wr(12'hFF8, 8'h00);
        chk(0, 16'h0FF8, 8'h00);
        mwr(16'h0412, 8'h00);
        chk(1, 16'h0412, 8'hFF);
        unlock(8'h02);
        wr(12'hFF8, 8'h95);
        idle;
        chk(1, 16'h0410, 8'hFF);
        chk(0, 16'h0FF8, 8'h00);
        wr(12'hFF8, 8'h00);
        wr(12'hFF9, 8'h02);
        wr(12'hFF8, 8'h8C);
        chk(0, 16'h0FF8, 8'h00);
        unlock(8'h02);
        wr(12'hFF8, 8'h63);
        chk(0, 16'h0FF8, 8'h00);
        wr(12'hFF8, 8'h5E);
        chk(0, 16'h0FF8, 8'h04);
        chk(0, 16'h0FF9, 8'h00);
        wr(12'hFF9, 8'h01);
        wr(12'hFF9, 8'h00);
        chk(0, 16'h0FF9, 8'h01);
        wr(12'hFF8, 8'h00);
        chk(0, 16'h0FF9, 8'h02);
        unlock(8'h02);
        mwr(16'h0413, 8'h00);
        chk(1, 16'h0413, 8'hFF);
        // A page write while unlocked is out of sequence and locks.
        wr(12'hFF9, 8'h82);
        chk(0, 16'h0FF8, 8'h00);
        wr(12'hFF9, 8'h82);
        chk(1, 16'hFE40, 8'h41);
        chk(1, 16'hFE53, 8'h54);
        chk(1, 16'hFE54, 8'h00);
        chk(2, 16'hFE40, 8'hFF);
        read_protect_i = 1'b1;
        debug_read_i = 1'b1;
        @(posedge clk_i);
        #1;
        `CHK(debug_read_block_o, 1'b1)
        {read_protect_i, debug_read_i} = 2'b00;
        // A second reset must drop the sector guard bits set above.
        sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        chk(0, 16'h0FF8, 8'h00);
        wr(12'hFF8, 8'h5E);
        chk(0, 16'h0FF9, 8'h00);
        report_and_stop;
    end
endmodule
bind flash_program_erase_controller flash_ctrl_properties props (
    .clk_i              (clk_i),
    .sys_rst_i          (sys_rst_i),
    .reg_wr_i           (reg_wr_i),
    .reg_addr_i         (reg_addr_i),
    .reg_wdata_i        (reg_wdata_i),
    .mem_wr_i           (mem_wr_i),
    .mem_fetch_i        (mem_fetch_i),
    .mem_addr_i         (mem_addr_i),
    .arr_rdata_i        (arr_rdata_i),
    .mem_rdata_o        (mem_rdata_o),
    .debug_read_i       (debug_read_i),
    .write_protect_i    (write_protect_i),
    .read_protect_i     (read_protect_i),
    .cpu_stall_o        (cpu_stall_o),
    .irq_defer_o        (irq_defer_o),
    .debug_read_block_o (debug_read_block_o),
    .arr_prog_o         (arr_prog_o),
    .arr_erase_o        (arr_erase_o),
    .arr_addr_o         (arr_addr_o)
);
